/* File: rtl/fpv_pkg.sv */
`default_nettype none
package fpv_pkg;
    // ==========================================
    // Register map (byte addresses)
    localparam logic [7:0] OFS_FLASH_CTRL = 8'h00;
    localparam logic [7:0] OFS_EBS_A      = 8'h04;
    localparam logic [7:0] OFS_EBS_B      = 8'h08;
    localparam logic [7:0] OFS_WSC        = 8'h0C;
    localparam logic [7:0] OFS_STATUS     = 8'h10;
    // ==========================================
    // Field positions
    localparam int FC_PROG_BIT    = 0;
    localparam int FC_ERASE_BIT   = 1;
    localparam int FC_PV_BIT      = 2;
    localparam int FC_EV_BIT      = 3;
    localparam int WSC_OVL_HI_BIT = 7;
    localparam int WSC_OVL_LO_BIT = 6;
    localparam int LARGE_BLKS     = 4;
    localparam int SMALL_BLKS     = 8;
    localparam int NUM_BLKS       = 12;
    // ==========================================
    // Reset values
    localparam logic [7:0] FC_RST    = 8'h00;
    localparam logic [7:0] EBS_A_RST = 8'h00;
    localparam logic [7:0] EBS_B_RST = 8'h00;
    localparam logic [7:0] WSC_RST   = 8'h08;
    // ==========================================
    // Overlap windows, flash side; RAM side is flash plus offset
    localparam logic [15:0] OVL_RAM_OFS = 16'hFC00;
    localparam logic [15:0] OVL_LO_BASE = 16'h0080;
    localparam logic [15:0] OVL_LO_LAST = 16'h00FF;
    localparam logic [15:0] OVL_HI_LAST = 16'h017F;
    localparam logic [15:0] OVL_VEC_BASE = 16'h0000;
    localparam logic [15:0] OVL_VEC_LAST = 16'h007F;
    // ==========================================
    // Types
    typedef enum logic [1:0] {
        LK_OPEN    = 2'b01,
        LK_TRIPPED = 2'b10
    } fpv_lock_t;
    typedef struct packed {
        logic [7:0] flash_ctrl;
        logic [7:0] ebs_a;
        logic [7:0] ebs_b;
        logic [7:0] wsc;
    } fpv_regs_t;
    typedef struct packed {
        logic                prog_act;
        logic                erase_act;
        logic                prewrite_verify;
        logic                prog_verify;
        logic                erase_verify;
        logic                rd_unreliable;
        logic [NUM_BLKS-1:0] blk_en;
    } fpv_prot_t;
    localparam fpv_regs_t REGS_RST = '{FC_RST, EBS_A_RST, EBS_B_RST, WSC_RST};
    function automatic logic fpv_in(input logic [15:0] a, input logic [15:0] lo,
                                    input logic [15:0] hi);
        fpv_in = (a >= lo) && (a <= hi);
    endfunction
endpackage
`default_nettype wire

/* File: rtl/fpv_protect.sv */
`timescale 1ns/1ps
`default_nettype none
module fpv_protect (
    input  wire logic              vpp_ok_i,
    input  wire logic              irq_i,
    input  wire logic              locked_i,
    input  wire fpv_pkg::fpv_regs_t regs_i,
    output fpv_pkg::fpv_prot_t     prot_o
);
    logic       emul_prot;
    logic       sw_prot;
    logic [3:0] mode;
    logic [fpv_pkg::NUM_BLKS-1:0] sel;

    // ==========================================
    // Protection evaluation, every cycle
    always_comb
    begin
        mode      = regs_i.flash_ctrl[3:0];
        sel       = {regs_i.ebs_a[fpv_pkg::LARGE_BLKS-1:0], regs_i.ebs_b};  // RULE5
        emul_prot = regs_i.wsc[fpv_pkg::WSC_OVL_HI_BIT] ^
                    regs_i.wsc[fpv_pkg::WSC_OVL_LO_BIT];  // RULE6
        sw_prot   = emul_prot || (sel == '0) || !vpp_ok_i || locked_i;  // RULE4
        // Abort is combinational so the cell sees no extra cycle of stress
        prot_o.prog_act  = mode[fpv_pkg::FC_PROG_BIT] && !sw_prot && !irq_i;  // RULE19
        prot_o.erase_act = mode[fpv_pkg::FC_ERASE_BIT] && !sw_prot && !irq_i;  // RULE10
        prot_o.blk_en    = sw_prot ? '0 : sel;  // RULE5
        prot_o.prewrite_verify = vpp_ok_i && (mode == 4'h0);  // RULE2
        prot_o.prog_verify  = vpp_ok_i && mode[fpv_pkg::FC_PV_BIT] &&
                              !mode[fpv_pkg::FC_PROG_BIT] && !mode[fpv_pkg::FC_ERASE_BIT];
        prot_o.erase_verify = vpp_ok_i && mode[fpv_pkg::FC_EV_BIT] &&
                              !mode[fpv_pkg::FC_PROG_BIT] && !mode[fpv_pkg::FC_ERASE_BIT];
        prot_o.rd_unreliable = mode[fpv_pkg::FC_PROG_BIT] || mode[fpv_pkg::FC_ERASE_BIT];  // RULE12
    end
endmodule
`default_nettype wire

/* File: rtl/fpv_overlap.sv */
`timescale 1ns/1ps
`default_nettype none
module fpv_overlap (
    input  wire logic        ovl_hi_i,
    input  wire logic        ovl_lo_i,
    input  wire logic        armed_i,
    input  wire logic [15:0] cpu_addr_i,
    output logic             hit_o,
    output logic [15:0]      ram_addr_o
);
    // ==========================================
    // Window select by overlap bits
    always_comb
    begin
        case ({ovl_hi_i, ovl_lo_i})  // RULE18
            2'b01:
            begin
                hit_o = fpv_pkg::fpv_in(cpu_addr_i, fpv_pkg::OVL_LO_BASE, fpv_pkg::OVL_LO_LAST);
            end
            2'b10:
            begin
                hit_o = fpv_pkg::fpv_in(cpu_addr_i, fpv_pkg::OVL_LO_BASE, fpv_pkg::OVL_HI_LAST);
            end
            2'b11:
            begin
                // Vector window only after the arming interrupt
                hit_o = armed_i &&
                        fpv_pkg::fpv_in(cpu_addr_i, fpv_pkg::OVL_VEC_BASE,
                                        fpv_pkg::OVL_VEC_LAST);  // RULE13
            end
            default:
            begin
                hit_o = 1'b0;
            end
        endcase
        // Wraps within 16 bits on purpose; carry has no meaning here
        ram_addr_o = hit_o ? 16'(cpu_addr_i + fpv_pkg::OVL_RAM_OFS) : cpu_addr_i;
    end
endmodule
`default_nettype wire

/* File: rtl/fpv_ctrl.sv */
// Operation
// RULE1: Software prewrites all flash and emulated RAM to zero before erase.
// RULE2: All four mode bits clear selects prewrite-verify; reads return verify data.
// RULE3: Software waits four microseconds after selecting prewrite-verify before reading.
// RULE4: Software protection blocks program and erase despite control bits set.
// RULE5: Block select registers gate blocks; F0 and 00 protect all.
// RULE6: Exactly one overlap bit set disables program and erase of all blocks.
// RULE7: Without programming voltage, control registers reset and all modes disabled; code keeps wait control unchanged and writable.
// RULE8: Any reset or standby initialises control registers and disables all modes; code leaves prewrite-verify selected while voltage is present.
// RULE9: External reset is held low ten clocks to guarantee reset.
// RULE10: Interrupt during program or erase aborts, keeps registers, blocks further.
// RULE11: Interrupt lockout clears only by reset, never by register write.
// RULE12: Reads while program or erase bit set are flagged unreliable.
// RULE13: Both overlap bits plus interrupt under voltage map vector RAM onto flash.
// RULE14: Software keeps NMI handler out of flash, vector in overlap RAM.
// RULE15: Boot-mode user code keeps boot vector and boot handler area intact.
// RULE16: Boot-mode user code without interrupts clears both overlap bits.
// RULE17: Software loads watchdog value per clock frequency band.
// RULE18: Overlap select bits sit at bits seven and six of wait control.
// RULE19: Program or erase active only when bit set and unprotected, each cycle.
`timescale 1ns/1ps
`default_nettype none
module fpv_ctrl (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic [31:0]      hrdata_o,
    input  wire logic        prog_voltage_pin_i,
    input  wire logic        standby_i,
    input  wire logic        wdt_reset_i,
    input  wire logic        irq_i,
    input  wire logic [15:0] cpu_addr_i,
    output logic             prog_act_o,
    output logic             erase_act_o,
    output logic             prewrite_verify_o,
    output logic             prog_verify_o,
    output logic             erase_verify_o,
    output logic             rd_unreliable_o,
    output logic [11:0]      blk_en_o,
    output logic             lockout_o,
    output logic             ovl_hit_o,
    output logic [15:0]      ovl_ram_addr_o
);
    // ==========================================
    // State
    typedef struct packed {
        fpv_pkg::fpv_regs_t regs;
        fpv_pkg::fpv_lock_t lock;
        logic               ovl_armed;
        logic               ap_wr;
        logic               ap_rd;
        logic [7:0]         ap_addr;
        logic [31:0]        hrdata;
    } fpv_state_t;

    localparam fpv_state_t STATE_RST = '{fpv_pkg::REGS_RST, fpv_pkg::LK_OPEN, 1'b0,
                                         1'b0, 1'b0, 8'h00, 32'h0000_0000};

    fpv_state_t          s_r;
    fpv_state_t          s_nxt;
    fpv_pkg::fpv_prot_t  prot;
    logic                locked;
    logic                both_ovl;
    logic                ap_valid;
    logic [7:0]          status;
    logic [fpv_pkg::NUM_BLKS-1:0] blk_sel;
    logic                emul;

    assign blk_sel  = {s_r.regs.ebs_a[fpv_pkg::LARGE_BLKS-1:0], s_r.regs.ebs_b};
    assign emul     = s_r.regs.wsc[fpv_pkg::WSC_OVL_HI_BIT] ^ s_r.regs.wsc[fpv_pkg::WSC_OVL_LO_BIT];

    assign locked   = (s_r.lock == fpv_pkg::LK_TRIPPED);
    assign both_ovl = s_r.regs.wsc[fpv_pkg::WSC_OVL_HI_BIT] &&
                      s_r.regs.wsc[fpv_pkg::WSC_OVL_LO_BIT];  // RULE18
    assign ap_valid = hsel_i && hready_i && htrans_i[1];

    // ==========================================
    // Protection and overlap
    fpv_protect u_protect (
        .vpp_ok_i (prog_voltage_pin_i),
        .irq_i    (irq_i),
        .locked_i (locked),
        .regs_i   (s_r.regs),
        .prot_o   (prot)
    );

    fpv_overlap u_overlap (
        .ovl_hi_i   (s_r.regs.wsc[fpv_pkg::WSC_OVL_HI_BIT]),
        .ovl_lo_i   (s_r.regs.wsc[fpv_pkg::WSC_OVL_LO_BIT]),
        .armed_i    (s_r.ovl_armed),
        .cpu_addr_i (cpu_addr_i),
        .hit_o      (ovl_hit_o),
        .ram_addr_o (ovl_ram_addr_o)
    );

    always_comb
    begin
        status = {1'b0, prot.rd_unreliable, s_r.ovl_armed, prot.prewrite_verify,
                  prot.erase_act, prot.prog_act, locked, prog_voltage_pin_i};
    end

    // ==========================================
    // Next state
    always_comb
    begin
        s_nxt = s_r;
        // Bus data phase: write lands here, read data already staged
        if (s_r.ap_wr)
        begin
            case (s_r.ap_addr)
                fpv_pkg::OFS_FLASH_CTRL: s_nxt.regs.flash_ctrl = hwdata_i[7:0];
                fpv_pkg::OFS_EBS_A:      s_nxt.regs.ebs_a      = hwdata_i[7:0];
                fpv_pkg::OFS_EBS_B:      s_nxt.regs.ebs_b      = hwdata_i[7:0];
                fpv_pkg::OFS_WSC:        s_nxt.regs.wsc        = hwdata_i[7:0];
                default:                 s_nxt.regs            = s_r.regs;
            endcase
        end
        if (hready_i)
        begin
            s_nxt.ap_wr   = ap_valid && hwrite_i;
            s_nxt.ap_rd   = ap_valid && !hwrite_i;
            s_nxt.ap_addr = haddr_i[7:0];
        end
        if (ap_valid && !hwrite_i)
        begin
            case (haddr_i[7:0])
                fpv_pkg::OFS_FLASH_CTRL: s_nxt.hrdata = {24'h000000, s_r.regs.flash_ctrl};
                fpv_pkg::OFS_EBS_A:      s_nxt.hrdata = {24'h000000, s_r.regs.ebs_a};
                fpv_pkg::OFS_EBS_B:      s_nxt.hrdata = {24'h000000, s_r.regs.ebs_b};
                fpv_pkg::OFS_WSC:        s_nxt.hrdata = {24'h000000, s_r.regs.wsc};
                fpv_pkg::OFS_STATUS:     s_nxt.hrdata = {24'h000000, status};
                default:                 s_nxt.hrdata = 32'h0000_0000;
            endcase
        end
        // Lockout: no bus path may clear it
        case (s_r.lock)
            fpv_pkg::LK_OPEN:
            begin
                // Sampled on the unabated request; prot is already forced low by irq
                if (irq_i && prog_voltage_pin_i && prot.rd_unreliable &&
                    (blk_sel != '0) && !emul)
                begin
                    s_nxt.lock = fpv_pkg::LK_TRIPPED;  // RULE10
                end
            end
            fpv_pkg::LK_TRIPPED:
            begin
                s_nxt.lock = fpv_pkg::LK_TRIPPED;  // RULE11
            end
            default:
            begin
                s_nxt.lock = fpv_pkg::LK_TRIPPED;
            end
        endcase
        // Vector overlap arms on interrupt with voltage present
        if (!both_ovl)
        begin
            s_nxt.ovl_armed = 1'b0;
        end
        else if (irq_i && prog_voltage_pin_i)
        begin
            s_nxt.ovl_armed = 1'b1;  // RULE13
        end
        // Hardware protection overrides any write this cycle; loss of voltage leaves wait control writable
        if (!prog_voltage_pin_i)
        begin
            s_nxt.regs.flash_ctrl = fpv_pkg::FC_RST;  // RULE7
            s_nxt.regs.ebs_a      = fpv_pkg::EBS_A_RST;
            s_nxt.regs.ebs_b      = fpv_pkg::EBS_B_RST;
        end
        if (standby_i || wdt_reset_i)
        begin
            s_nxt.regs      = fpv_pkg::REGS_RST;  // RULE8
            s_nxt.ovl_armed = 1'b0;
        end
        if (wdt_reset_i)
        begin
            s_nxt.lock = fpv_pkg::LK_OPEN;  // RULE11
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            s_r <= STATE_RST;  // RULE8
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // ==========================================
    // Outputs
    // Zero wait states, so the bus never sees a stalled slave
    assign hreadyout_o       = 1'b1;
    assign hresp_o           = 1'b0;
    assign hrdata_o          = s_r.hrdata;
    assign prog_act_o        = prot.prog_act;
    assign erase_act_o       = prot.erase_act;
    assign prewrite_verify_o = prot.prewrite_verify;
    assign prog_verify_o     = prot.prog_verify;
    assign erase_verify_o    = prot.erase_verify;
    assign rd_unreliable_o   = prot.rd_unreliable;
    assign blk_en_o          = prot.blk_en;
    assign lockout_o         = locked;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_active;
        prog_act_o || erase_act_o;
    endsequence
    sequence s_hit_by_irq;
        s_active ##1 (irq_i && !wdt_reset_i && !standby_i && prog_voltage_pin_i);
    endsequence

    a_vpp_off_modes: assert property (!prog_voltage_pin_i |-> !prog_act_o && !erase_act_o
        && !prewrite_verify_o && !prog_verify_o && !erase_verify_o)  // RULE7
        else $error("mode active without programming voltage");
    a_vpp_off_regs: assert property (!prog_voltage_pin_i |=> s_r.regs.flash_ctrl == 8'h00
        && s_r.regs.ebs_a == 8'h00 && s_r.regs.ebs_b == 8'h00)  // RULE7
        else $error("control registers kept without voltage");
    a_reset_init: assert property ((standby_i || wdt_reset_i) |=>
        s_r.regs == fpv_pkg::REGS_RST && !prog_act_o && !erase_act_o)  // RULE8
        else $error("registers not initialised by reset or standby");
    a_irq_abort: assert property (irq_i |-> !prog_act_o && !erase_act_o)  // RULE10
        else $error("program or erase not aborted by interrupt");
    a_irq_lock_keep: assert property (s_hit_by_irq |=> lockout_o
        && s_r.regs.flash_ctrl == $past(s_r.regs.flash_ctrl, 2)
        || $past(s_r.ap_wr))  // RULE10
        else $error("interrupt did not lock or lost settings");
    a_lock_sticky: assert property (lockout_o && !wdt_reset_i |=> lockout_o)  // RULE11
        else $error("lockout cleared without reset");
    a_lock_blocks: assert property (lockout_o |-> !prog_act_o && !erase_act_o)  // RULE10
        else $error("program or erase while locked");
    a_emul_prot: assert property ((s_r.regs.wsc[7] ^ s_r.regs.wsc[6]) |->
        !prog_act_o && !erase_act_o && blk_en_o == 12'h000)  // RULE6
        else $error("emulation protect not applied");
    a_blk_all_prot: assert property (s_r.regs.ebs_a == 8'hF0 && s_r.regs.ebs_b == 8'h00
        |-> !prog_act_o && !erase_act_o && blk_en_o == 12'h000)  // RULE5
        else $error("all-block protect not applied");
    a_pw_verify: assert property (prog_voltage_pin_i && s_r.regs.flash_ctrl[3:0] == 4'h0
        |-> prewrite_verify_o)  // RULE2
        else $error("prewrite verify not selected");
    a_act_cause: assert property (prog_act_o |-> s_r.regs.flash_ctrl[0]
        && prog_voltage_pin_i && !lockout_o && blk_en_o != 12'h000)  // RULE19
        else $error("program active without its cause");
    a_rd_unrel: assert property ((s_r.regs.flash_ctrl[1:0] != 2'b00) |-> rd_unreliable_o)  // RULE12
        else $error("unreliable read not flagged");
    a_ovl_vec: assert property (both_ovl && irq_i && prog_voltage_pin_i && !standby_i
        && !wdt_reset_i && !s_r.ap_wr ##1 cpu_addr_i == 16'h0006
        |-> ovl_hit_o && ovl_ram_addr_o == 16'hFC06)  // RULE13
        else $error("vector overlap not mapped");
endmodule
`default_nettype wire

/* File: tb/fpv_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// CPU software side: single-word AHB-Lite master
module fpv_cpu_model (
    input  wire logic        clk_i,
    input  wire logic        hready_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic [31:0]      haddr_o,
    output logic [1:0]       htrans_o,
    output logic             hwrite_o,
    output logic [2:0]       hsize_o,
    output logic [31:0]      hwdata_o
);
    initial
    begin
        hsel_o   = 1'b0;
        haddr_o  = 32'h00000000;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o  = 3'h2;
        hwdata_o = 32'h00000000;
    end
    // No fixed latency assumed; the bench watchdog ends a hung wait
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        hsel_o   <= 1'b1;
        haddr_o  <= {24'h000000, a};
        htrans_o <= 2'h2;
        hwrite_o <= wr;
        hwdata_o <= ~hwdata_o;
        @(posedge clk_i);
        while (hready_i !== 1'b1)
            @(posedge clk_i);
        hsel_o   <= 1'b0;
        htrans_o <= 2'h0;
        hwdata_o <= d;
        @(posedge clk_i);
        while (hready_i !== 1'b1)
            @(posedge clk_i);
        q = hrdata_i;
    endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk_i, rst_b_i, vpp, stby, wdt, irq;
    logic        hsel, hwr, hrdy, hresp, p, e, pwv, pv, ev, unr, lk, hit;
    logic [31:0] haddr, hwd, hrd;
    logic [1:0]  htr;
    logic [2:0]  hsz;
    logic [11:0] blk;
    logic [15:0] ca, ra;
    logic [7:0]  m_fc, m_a, m_b, m_w, codes [5];
    logic        m_lk, m_arm;
    int          n_fail, n_checks, seed, i, j;

    fpv_ctrl uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htr), .hwrite_i(hwr), .hsize_i(hsz), .hwdata_i(hwd), .hready_i(hrdy),
        .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrd), .prog_voltage_pin_i(vpp),
        .standby_i(stby), .wdt_reset_i(wdt), .irq_i(irq), .cpu_addr_i(ca),
        .prog_act_o(p), .erase_act_o(e), .prewrite_verify_o(pwv), .prog_verify_o(pv),
        .erase_verify_o(ev), .rd_unreliable_o(unr), .blk_en_o(blk), .lockout_o(lk),
        .ovl_hit_o(hit), .ovl_ram_addr_o(ra));
    fpv_cpu_model cpu (.clk_i(clk_i), .hready_i(hrdy), .hrdata_i(hrd), .hsel_o(hsel),
        .haddr_o(haddr), .htrans_o(htr), .hwrite_o(hwr), .hsize_o(hsz), .hwdata_o(hwd));

    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // ==========================================
    // Reference model
    function automatic logic [31:0] exp_out();
        logic ok, h;
        ok = vpp & ~irq & ~m_lk & ~(m_w[7] ^ m_w[6]) & ((m_a[3:0] != 4'h0) | (m_b != 8'h00));
        case (m_w[7:6])
            2'b01:   h = (ca >= 16'h0080) && (ca <= 16'h00FF);
            2'b10:   h = (ca >= 16'h0080) && (ca <= 16'h017F);
            2'b11:   h = m_arm && (ca <= 16'h007F);
            default: h = 1'b0;
        endcase
        exp_out = {8'h00, m_fc[0] & ok, m_fc[1] & ok, vpp & (m_fc[3:0] == 4'h0),
                   vpp & m_fc[2], vpp & m_fc[3], m_fc[0] | m_fc[1], m_lk, h,
                   h ? ca + 16'hFC00 : ca};
    endfunction
    function automatic logic [7:0] exp_stat();
        logic [31:0] o;
        o = exp_out();
        exp_stat = {1'b0, o[18], m_arm, o[21], o[22], o[23], m_lk, vpp};
    endfunction
    // ==========================================
    // Compare and bus tasks
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_out();
        #1;
        cmp({7'h00, hresp, p, e, pwv, pv, ev, unr, lk, hit, ra}, exp_out());
    endtask
    task automatic chk_blk();
        logic en;
        en = vpp & ~m_lk & ~(m_w[7] ^ m_w[6]) & ({m_a[3:0], m_b} != 12'h000);
        cmp({20'h0, blk}, en ? {20'h0, m_a[3:0], m_b} : 32'h0);
    endtask
    task automatic r(input logic [7:0] o, input logic [7:0] v);
        logic [31:0] q;
        cpu.xfer(1'b0, o, 32'h0, q);
        cmp(q, {24'h0, v});
    endtask
    task automatic w(input logic [7:0] o, input logic [7:0] v);
        logic [31:0] q;
        cpu.xfer(1'b1, o, {24'h0, v}, q);
        if (vpp && o == fpv_pkg::OFS_FLASH_CTRL) m_fc = v;
        if (vpp && o == fpv_pkg::OFS_EBS_A) m_a = v;
        if (vpp && o == fpv_pkg::OFS_EBS_B) m_b = v;
        if (o == fpv_pkg::OFS_WSC) m_w = v;
        if (o == fpv_pkg::OFS_WSC && v[7:6] != 2'b11) m_arm = 1'b0;
        chk_out();
    endtask
    task automatic clr_model();
        {m_fc, m_a, m_b, m_w, m_lk, m_arm} = {24'h0, 8'h08, 2'b00};
    endtask
    // One-cycle pulse on watchdog (0), standby (1) or interrupt (other)
    task automatic pulse(input int k);
        @(posedge clk_i);
        case (k)
            0:       wdt <= 1'b1;
            1:       stby <= 1'b1;
            default: irq <= 1'b1;
        endcase
        @(posedge clk_i);
        {wdt, stby, irq} <= 3'b000;
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        clr_model();
    endtask
    task automatic trip();
        w(fpv_pkg::OFS_FLASH_CTRL, 8'h01);
        @(posedge clk_i);
        irq <= 1'b1;
        chk_out();
        @(posedge clk_i);
        irq <= 1'b0;
        m_lk = 1'b1;
        chk_out();
    endtask
    task automatic summarize();
        $display("checks=%0d fails=%0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Generous bound, run needs about a thousand cycles
    initial
    begin
        #200000;
        n_fail++;
        summarize();
    end
    // ==========================================
    // Main sequence
    initial
    begin
        {rst_b_i, vpp, stby, wdt, irq, ca, seed} = {5'h0, 16'h0, 32'd11288};
        {n_fail, n_checks} = 0;
        codes = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00};
        do_reset();
        @(posedge clk_i);
        vpp <= 1'b1;
        r(fpv_pkg::OFS_FLASH_CTRL, 8'h00);
        r(fpv_pkg::OFS_EBS_A, 8'h00);
        r(fpv_pkg::OFS_EBS_B, 8'h00);
        r(fpv_pkg::OFS_WSC, 8'h08);
        r(8'h14, 8'h00);
        w(fpv_pkg::OFS_EBS_A, 8'h0F);
        w(fpv_pkg::OFS_EBS_B, 8'hFF);
        for (i = 0; i < 5; i++)
        begin
            w(fpv_pkg::OFS_FLASH_CTRL, codes[i]);
            chk_blk();
        end
        repeat (800) @(posedge clk_i);
        r(fpv_pkg::OFS_STATUS, exp_stat());
        w(fpv_pkg::OFS_EBS_A, 8'hF0);
        w(fpv_pkg::OFS_EBS_B, 8'h00);
        w(fpv_pkg::OFS_FLASH_CTRL, 8'h01);
        chk_blk();
        w(fpv_pkg::OFS_FLASH_CTRL, 8'h04);
        w(fpv_pkg::OFS_EBS_A, 8'h0F);
        w(fpv_pkg::OFS_EBS_B, 8'hFF);
        for (i = 1; i < 3; i++)
        begin
            w(fpv_pkg::OFS_WSC, {i[1:0], 6'h08});
            w(fpv_pkg::OFS_FLASH_CTRL, 8'h02);
            chk_blk();
            w(fpv_pkg::OFS_FLASH_CTRL, 8'h08);
            r(fpv_pkg::OFS_WSC, {i[1:0], 6'h08});
        end
        w(fpv_pkg::OFS_WSC, 8'h08);
        trip();
        r(fpv_pkg::OFS_FLASH_CTRL, 8'h01);
        r(fpv_pkg::OFS_EBS_B, 8'hFF);
        w(fpv_pkg::OFS_FLASH_CTRL, 8'h00);
        w(fpv_pkg::OFS_FLASH_CTRL, 8'h02);
        w(fpv_pkg::OFS_FLASH_CTRL, 8'h04);
        r(fpv_pkg::OFS_STATUS, exp_stat());
        pulse(0);
        clr_model();
        chk_out();
        w(fpv_pkg::OFS_EBS_A, 8'h03);
        trip();
        do_reset();
        chk_out();
        w(fpv_pkg::OFS_EBS_B, 8'h11);
        w(fpv_pkg::OFS_FLASH_CTRL, 8'h02);
        @(posedge clk_i);
        vpp <= 1'b0;
        @(posedge clk_i);
        {m_fc, m_a, m_b} = 24'h0;
        chk_out();
        w(fpv_pkg::OFS_FLASH_CTRL, 8'h01);
        r(fpv_pkg::OFS_FLASH_CTRL, 8'h00);
        r(fpv_pkg::OFS_EBS_B, 8'h00);
        @(posedge clk_i);
        vpp <= 1'b1;
        w(fpv_pkg::OFS_EBS_B, 8'h22);
        w(fpv_pkg::OFS_FLASH_CTRL, 8'h01);
        pulse(1);
        clr_model();
        chk_out();
        r(fpv_pkg::OFS_EBS_B, 8'h00);
        for (i = 0; i < 4; i++)
        begin
            w(fpv_pkg::OFS_WSC, {i[1:0], 6'h08});
            pulse(2);
            if (i == 3) m_arm = 1'b1;
            for (j = 0; j < 12; j++)
            begin
                @(posedge clk_i);
                ca <= {7'h00, 9'($random(seed))};
                chk_out();
            end
        end
        @(posedge clk_i);
        ca <= 16'h0006;
        chk_out();
        w(fpv_pkg::OFS_WSC, 8'h08);
        summarize();
    end
endmodule
`default_nettype wire
